// file: include/adc_rpt_pkg.sv
// Shared constants, types and timing figures of the repeat-mode converter control
package adc_rpt_pkg;

   // ----------------------------------------------------------------
   // Register map (word index; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int WB_ADR_W = 10;
   localparam logic [7:0] IDX_CTRL0 = 8'hD6;
   localparam logic [7:0] IDX_CTRL1 = 8'hD7;
   localparam logic [7:0] IDX_CTRL2 = 8'hD8;
   localparam logic [7:0] IDX_RESULT = 8'hD9;

   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL2 = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PIN_LSB = 0;
   localparam int MODE_BIT = 3;
   localparam int GROUP_BIT = 4;
   localparam int TRIG_BIT = 5;
   localparam int RUN_BIT = 6;
   localparam int CKL_BIT = 7;
   localparam int RES_BIT = 3;
   localparam int CKH_BIT = 4;
   localparam int REF_BIT = 5;
   localparam int SH_BIT = 0;

   // ----------------------------------------------------------------
   // Conversion phases, in half converter-clock cycles
   // ----------------------------------------------------------------
   localparam logic [6:0] HALF_SAMPLE_FIRST = 7'h08;
   localparam logic [6:0] HALF_CMP_FIRST_NSH = 7'h04;
   localparam logic [6:0] HALF_CMP_FIRST_SH = 7'h05;
   localparam logic [6:0] HALF_SAMPLE_NEXT_NSH = 7'h05;
   localparam logic [6:0] HALF_SAMPLE_NEXT_SH = 7'h00;
   localparam logic [6:0] HALF_CMP_NEXT = 7'h05;
   localparam logic [6:0] HALF_END_NSH = 7'h10;
   localparam logic [6:0] HALF_END_SH = 7'h08;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_10 = 4'hA;

   typedef enum logic [1:0] {
      CKS_DIV4 = 2'h0,
      CKS_DIV2 = 2'h1,
      CKS_DIV1 = 2'h2,
      CKS_FAST = 2'h3
   } cks_t;

   function automatic logic [6:0] first_bound(input logic sh);
      first_bound = HALF_SAMPLE_FIRST + (sh ? HALF_CMP_FIRST_SH : HALF_CMP_FIRST_NSH);
   endfunction : first_bound

   function automatic logic [6:0] bit_period(input logic sh);
      bit_period = (sh ? HALF_SAMPLE_NEXT_SH : HALF_SAMPLE_NEXT_NSH) + HALF_CMP_NEXT;
   endfunction : bit_period

   function automatic logic [6:0] conv_total(input logic sh, input logic ten);
      logic [6:0] later;
      later = bit_period(sh) * (ten ? 7'h09 : 7'h07);
      conv_total = first_bound(sh) + later + (sh ? HALF_END_SH : HALF_END_NSH);
   endfunction : conv_total

endpackage : adc_rpt_pkg

// file: tb/adc_far_side.sv
// Far-side model: analog sources, comparator and capture timer
`timescale 1ns/1ps
module adc_far_side (
   input wire logic i_clk,
   input wire logic [3:0] i_sel,
   input wire logic [9:0] i_dac,
   output logic o_cmp_high,
   output logic o_timer_irq
);
   logic [9:0] ain [4];
   logic [9:0] level;
   logic ten;

   // ----------------------------------------------------------------
   // Comparator
   // ----------------------------------------------------------------
   assign level = i_sel[0] ? ain[0] : i_sel[1] ? ain[1] : i_sel[2] ? ain[2] : i_sel[3] ? ain[3] : 10'h000;
   // Bench sets ten only for one-shot runs; repeat runs stay 8-bit
   // No pin selected gives a low comparator, so a dead mux shows as result 0
   assign o_cmp_high = (i_sel != 4'h0) && (ten ? (level >= i_dac) : (level[7:0] >= i_dac[7:0]));

   initial begin
      o_timer_irq = 1'b0;
      ten = 1'b0;
      ain[0] = 10'h05A;
      ain[1] = 10'h0C3;
      ain[2] = 10'h001;
      ain[3] = 10'h0FE;
   end

   // ----------------------------------------------------------------
   // Capture timer request
   // ----------------------------------------------------------------
   task automatic fire_timer;
      @(posedge i_clk);
      o_timer_irq <= 1'b1;
      @(posedge i_clk);
      o_timer_irq <= 1'b0;
   endtask : fire_timer
endmodule : adc_far_side

// file: tb/tb_adc_repeat_ctrl.sv
// Self-checking bench for the repeat-mode converter control
`timescale 1ns/1ps
module tb_adc_repeat_ctrl
   import adc_rpt_pkg::*;
;
   localparam int FASTH = 3;
   logic clk, rst_n, cyc, stb, we, ack, cmp_high, timer_irq, sample, hold_en, ref_con, busy;
   logic [WB_ADR_W-1:0] adr;
   logic [3:0] sel;
   logic [3:0] in_sel;
   logic [31:0] wdat, rdat, q;
   logic [9:0] dac;
   logic [7:0] idxs [5];
   int err_total, n_compared, cyc_n, hi_n, st, prev_st, period, n_long, thr;
   int exp_per [4];

   adc_repeat_ctrl #(.FAST_HALF(FASTH)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_TIMER_IRQ(timer_irq), .I_CMP_HIGH(cmp_high), .O_DAC_CODE(dac), .O_INPUT_SEL(in_sel),
      .O_SAMPLE(sample), .O_HOLD_EN(hold_en), .O_REF_CONNECT(ref_con), .O_BUSY(busy));
   adc_far_side far (.i_clk(clk), .i_sel(in_sel), .i_dac(dac), .o_cmp_high(cmp_high), .o_timer_irq(timer_irq));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Conversion period monitor
   // ----------------------------------------------------------------
   // Only sampling stretches of at least thr cycles mark a conversion start
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (sample === 1'b1) begin
         if (hi_n == 0) st <= cyc_n;
         hi_n <= hi_n + 1;
      end else begin
         if (hi_n >= thr) begin
            period <= st - prev_st;
            prev_st <= st;
            n_long <= n_long + 1;
         end
         hi_n <= 0;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) err_total++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic check_near(input int got, input int exp);
      n_compared++;
      if (got < exp - 2 || got > exp + 2) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_near

   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_busy

   task automatic wait_starts(input int k);
      int n0, n;
      n0 = n_long;
      n = 0;
      while (n_long < n0 + k && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n_long < n0 + k) err_total++;
   endtask : wait_starts

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {rst_n, cyc, stb, we} = 4'h0;
      adr = '0;
      sel = 4'h0;
      wdat = 32'h00000000;
      {err_total, n_compared, cyc_n, hi_n, st, prev_st, period, n_long, thr} = '0;
      idxs = '{IDX_CTRL0, IDX_CTRL1, IDX_CTRL2, IDX_RESULT, 8'h10};
      exp_per = '{112, 56, 28, 56 * FASTH};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, idxs[i], 8'h00);
         check(q, 32'h00000000);
      end
      wb(1'b1, IDX_CTRL1, 8'hC7);
      wb(1'b0, IDX_CTRL1, 8'h00);
      check(q, 32'h000000C7);
      wb(1'b1, IDX_CTRL1, 8'h20);
      repeat (20) @(posedge clk);
      check(ref_con, 1'b1);
      $display("register test done");
      for (int p = 0; p < 4; p++) begin
         wb(1'b1, IDX_CTRL0, 8'h1C + p[7:0]);
         repeat (2) @(posedge clk);
         check(in_sel, 4'h1 << p);
      end
      wb(1'b1, IDX_CTRL0, 8'h0F);
      repeat (2) @(posedge clk);
      check(in_sel, 4'h0);
      $display("pin select test done");
      thr = 2;
      wb(1'b1, IDX_CTRL2, 8'h01);
      repeat (2) @(posedge clk);
      check(hold_en, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, IDX_CTRL1, c[1] ? 8'h30 : 8'h20);
         wb(1'b1, IDX_CTRL0, {c[0], 7'h5C});
         wait_starts(3);
         check_near(period, exp_per[c]);
         wb(1'b1, IDX_CTRL0, {c[0], 7'h1C});
         wait_busy(1'b0, 4);
      end
      $display("clock and sample-hold test done");
      thr = 13;
      wb(1'b1, IDX_CTRL2, 8'h00);
      wb(1'b1, IDX_CTRL1, 8'h20);
      wb(1'b1, IDX_CTRL0, 8'h5C);
      wait_busy(1'b1, 3);
      check(busy, 1'b1);
      wait_starts(3);
      check_near(period, 196);
      wb(1'b0, IDX_RESULT, 8'h00);
      check(q, 32'h0000005A);
      far.ain[0] = 10'h033;
      wait_starts(2);
      wb(1'b0, IDX_RESULT, 8'h00);
      check(q, 32'h00000033);
      wb(1'b0, IDX_CTRL0, 8'h00);
      check(q, 32'h0000005C);
      wb(1'b1, IDX_CTRL0, 8'h1C);
      wait_busy(1'b0, 3);
      check(busy, 1'b0);
      $display("repeat test done");
      wb(1'b1, IDX_CTRL0, 8'h7C);
      repeat (10) @(posedge clk);
      check(busy, 1'b0);
      far.fire_timer();
      wait_busy(1'b1, 5);
      check(busy, 1'b1);
      wb(1'b1, IDX_CTRL0, 8'h3C);
      wait_busy(1'b0, 3);
      check(busy, 1'b0);
      $display("timer test done");
      far.ten = 1'b1;
      far.ain[0] = 10'h2A5;
      wb(1'b1, IDX_CTRL1, 8'h28);
      wb(1'b1, IDX_CTRL0, 8'h94);
      wb(1'b1, IDX_CTRL0, 8'hD4);
      wait_busy(1'b1, 5);
      wait_busy(1'b0, 400);
      check(busy, 1'b0);
      wb(1'b0, IDX_RESULT, 8'h00);
      check(q, 32'h000002A5);
      wb(1'b0, IDX_CTRL0, 8'h00);
      check(q, 32'h00000094);
      $display("ten-bit test done");
      report_and_stop();
   end
endmodule : tb_adc_repeat_ctrl

// file: verilog/adc_clk_div.sv
// Converter clock divider producing half-cycle advance steps
`timescale 1ns/1ps
module adc_clk_div
   import adc_rpt_pkg::*;
#(
   parameter int FAST_HALF = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire cks_t i_sel,
   input wire logic i_run,
   output logic [1:0] o_step
);
   if (FAST_HALF < 1 || FAST_HALF > 255) begin : g_bad_fast
      $error("FAST_HALF out of range");
   end

   logic [7:0] cnt_r;
   logic [7:0] half_len;
   logic [1:0] weight;

   assign half_len = (i_sel == CKS_DIV4) ? 8'h02 :
                     (i_sel == CKS_FAST) ? 8'(FAST_HALF) : 8'h01;
   // Undivided clock is faster than one half step per cycle, so it advances two
   assign weight = (i_sel == CKS_DIV1) ? 2'h2 : 2'h1;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 8'h00;
         o_step <= 2'h0;
      end else if (!i_run || cnt_r >= half_len - 8'h01) begin
         cnt_r <= 8'h00;
         o_step <= i_run ? weight : 2'h0;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         o_step <= 2'h0;
      end
   end

   a_div4_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_sel == CKS_DIV4 && $stable(i_sel) && i_run && o_step != 2'h0) |=> (o_step == 2'h0))
      else $error("divide-by-four step came too soon");

endmodule : adc_clk_div

// file: verilog/adc_repeat_ctrl.sv
// Converter control: registers, triggering, phase sequencing and result capture
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps

// Contract
// - repeat mode reconverts selected input continuously
// - software trigger starts on run write
// - timer request starts when run set
// - repeat mode never self-clears run
// - repeat mode raises no completion request
// - pin codes 100..111 pick inputs 8..11
// - pin select only with group enabled
// - control writes mid-conversion spoil result
// - two select bits choose converter clock
// - sample-hold gives 28 or 33 cycles
// - sample-hold chosen before starting conversion
// - plain timing 4/2/2.5/2.5/8 cycles
// - sample-hold timing 4/2.5/0/2.5/4 cycles
// - each result lands in result register
// - resolution bit selects 10 or 8 bits
// - clearing run aborts, result undefined
module adc_repeat_ctrl
   import adc_rpt_pkg::*;
#(
   parameter int FAST_HALF = 1
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [WB_ADR_W-1:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic I_TIMER_IRQ,
   input wire logic I_CMP_HIGH,
   output logic [9:0] O_DAC_CODE,
   output logic [3:0] O_INPUT_SEL,
   output logic O_SAMPLE,
   output logic O_HOLD_EN,
   output logic O_REF_CONNECT,
   output logic O_BUSY
);
   if (FAST_HALF < 1 || FAST_HALF > 255) begin : g_bad_fast
      $error("FAST_HALF out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV
   } state_t;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic ack_r;
   logic [31:0] rdata_r;
   logic [7:0] ctrl0_r;
   logic [7:0] ctrl1_r;
   logic [7:0] ctrl2_r;
   logic [9:0] result_r;
   logic run_r;
   logic run_nxt;

   wire [7:0] reg_idx = I_WB_ADR[WB_ADR_W-1:2];
   wire req = I_WB_CYC & I_WB_STB;
   wire hit0 = (reg_idx == IDX_CTRL0);
   wire hit1 = (reg_idx == IDX_CTRL1);
   wire hit2 = (reg_idx == IDX_CTRL2);
   wire hit_res = (reg_idx == IDX_RESULT);
   // Writes commit on the edge where the master sees the acknowledge
   wire wr_lane = req & I_WB_WE & ack_r & I_WB_SEL[0];
   wire wr0 = wr_lane & hit0;
   wire wr1 = wr_lane & hit1;
   wire wr2 = wr_lane & hit2;
   wire [7:0] ctrl0_view = {ctrl0_r[7], run_r, ctrl0_r[5:0]};
   wire [31:0] rd_mux = hit0 ? {24'h000000, ctrl0_view} :
                        hit1 ? {24'h000000, ctrl1_r} :
                        hit2 ? {24'h000000, ctrl2_r} :
                        hit_res ? {22'h000000, result_r} : 32'h00000000;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r <= req & ~ack_r;
         rdata_r <= (req & ~ack_r) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl0_r <= RST_CTRL0;
         ctrl1_r <= RST_CTRL1;
         ctrl2_r <= RST_CTRL2;
      end else begin
         if (wr0) begin
            ctrl0_r <= I_WB_DAT[7:0];
         end
         if (wr1) begin
            ctrl1_r <= I_WB_DAT[7:0];
         end
         if (wr2) begin
            ctrl2_r <= I_WB_DAT[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Control field decode
   // ----------------------------------------------------------------
   wire [2:0] pin_sel = ctrl0_r[PIN_LSB +: 3];
   wire repeat_md = ctrl0_r[MODE_BIT];
   wire group_en = ctrl0_r[GROUP_BIT];
   wire trig_timer = ctrl0_r[TRIG_BIT];
   wire ten_bit = ctrl1_r[RES_BIT];
   wire sh_en = ctrl2_r[SH_BIT];
   wire cks_t cks_sel = cks_t'({ctrl1_r[CKH_BIT], ctrl0_r[CKL_BIT]});

   // ----------------------------------------------------------------
   // Trigger and sequencing
   // ----------------------------------------------------------------
   state_t state_r;
   state_t state_nxt;
   logic timer_q;
   logic [1:0] step;
   logic [6:0] cnt_r;
   logic [6:0] bound_r;
   logic [6:0] total_r;
   logic [3:0] bits_left_r;
   logic [9:0] core_result;
   logic [9:0] core_dac;
   logic sample_r;

   wire timer_rise = I_TIMER_IRQ & ~timer_q;
   wire busy = (state_r == ST_CONV);
   wire [6:0] cnt_sum = cnt_r + {5'h00, step};
   wire bit_hit = busy && bits_left_r != 4'h0 && cnt_sum >= bound_r;
   wire conv_done = busy && bits_left_r == 4'h0 && cnt_sum >= total_r;

   wire sw_start = wr0 & I_WB_DAT[RUN_BIT] & ~I_WB_DAT[TRIG_BIT];
   wire hw_start = run_r & trig_timer & timer_rise;
   wire first_start = (state_r == ST_IDLE) & (sw_start | hw_start);
   wire again = conv_done & repeat_md & run_nxt;
   wire restart = first_start | again;

   // only one-shot completion clears run; a write in the same cycle wins
   always_comb begin
      run_nxt = run_r;
      if (conv_done && !repeat_md) begin
         run_nxt = 1'b0;
      end
      if (wr0) begin
         run_nxt = I_WB_DAT[RUN_BIT];
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (first_start) begin
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (!run_nxt || (conv_done && !again)) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_r <= ST_IDLE;
         run_r <= 1'b0;
         timer_q <= 1'b0;
      end else begin
         state_r <= state_nxt;
         run_r <= run_nxt;
         timer_q <= I_TIMER_IRQ;
      end
   end

   // cycle budget fixed by sample-hold and width
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cnt_r <= 7'h00;
         bound_r <= 7'h00;
         total_r <= 7'h00;
         bits_left_r <= 4'h0;
      end else if (restart) begin
         cnt_r <= 7'h00;
         bound_r <= first_bound(sh_en);
         total_r <= conv_total(sh_en, ten_bit);
         bits_left_r <= ten_bit ? BITS_10 : BITS_8;
      end else if (busy) begin
         cnt_r <= cnt_sum;
         if (bit_hit) begin
            bound_r <= bound_r + bit_period(sh_en);
            bits_left_r <= bits_left_r - 4'h1;
         end
      end
   end

   // Sampling lasts while more than a comparison slot remains before the bit ends
   wire first_bit = busy && (bits_left_r == (ten_bit ? BITS_10 : BITS_8));
   wire [6:0] cmp_len = first_bit ? (first_bound(sh_en) - HALF_SAMPLE_FIRST) : HALF_CMP_NEXT;
   wire sample_now = busy && bits_left_r != 4'h0 && (bound_r - cnt_r) > cmp_len;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sample_r <= 1'b0;
      end else begin
         sample_r <= sample_now & ~restart;
      end
   end

   // ----------------------------------------------------------------
   // Clock divider and approximation register
   // ----------------------------------------------------------------
   adc_clk_div #(
      .FAST_HALF(FAST_HALF)
   ) u_div (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_sel(cks_sel),
      .i_run(busy & ~restart),
      .o_step(step)
   );

   adc_sar_core u_sar (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_start(restart),
      .i_bit(bit_hit),
      .i_ten(ten_bit),
      .i_cmp(I_CMP_HIGH),
      .o_dac(core_dac),
      .o_result(core_result)
   );

   // ----------------------------------------------------------------
   // Result and pin outputs
   // ----------------------------------------------------------------
   // upper pin codes map to inputs
   wire [3:0] pin_onehot = (group_en && pin_sel[2]) ? (4'h1 << pin_sel[1:0]) : 4'h0;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         result_r <= 10'h000;
         O_INPUT_SEL <= 4'h0;
         O_HOLD_EN <= 1'b0;
         O_REF_CONNECT <= 1'b0;
         O_BUSY <= 1'b0;
      end else begin
         if (conv_done) begin
            result_r <= core_result;
         end
         O_INPUT_SEL <= pin_onehot;
         O_HOLD_EN <= sh_en;
         O_REF_CONNECT <= ctrl1_r[REF_BIT];
         O_BUSY <= busy;
      end
   end

   assign O_WB_ACK = ack_r;
   assign O_WB_DAT = rdata_r;
   assign O_DAC_CODE = core_dac;
   assign O_SAMPLE = sample_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_repeat_restart: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (conv_done && repeat_md && run_r && !wr0) |=> (state_r == ST_CONV && cnt_r == 7'h00))
      else $error("repeat mode did not restart conversion");

   a_soft_start: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (state_r == ST_IDLE && sw_start) |=> (state_r == ST_CONV) ##1 O_BUSY)
      else $error("software start not honoured");

   a_timer_start: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (state_r == ST_IDLE && !wr0 && (!run_r || !trig_timer)) |=> (state_r == ST_IDLE || $past(sw_start)))
      else $error("conversion began without a trigger");

   a_run_kept: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (repeat_md && run_r && !wr0) |=> run_r)
      else $error("run cleared by hardware in repeat mode");

   a_pin_select: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (!group_en && $stable(ctrl0_r)) |=> (O_INPUT_SEL == 4'h0))
      else $error("input selected while group disabled");

   a_conv_length: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      conv_done |-> (cnt_sum >= total_r && total_r == conv_total(sh_en, ten_bit) && bits_left_r == 4'h0))
      else $error("conversion length wrong");

   a_result_update: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      conv_done |=> (result_r == $past(core_result)))
      else $error("result not replaced by newest conversion");

   a_stop_abort: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (busy && wr0 && !I_WB_DAT[RUN_BIT]) |=> (state_r == ST_IDLE) ##1 !O_BUSY)
      else $error("clearing run did not stop conversion");

   a_sample_first: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      restart |-> ##2 O_SAMPLE)
      else $error("first bit did not open with sampling");

   a_plain_resample: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (bit_hit && !sh_en && bits_left_r > 4'h1) |=> ##1 O_SAMPLE)
      else $error("later bit skipped its sampling phase");

   a_hold_no_resample: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (busy && sh_en && !first_bit) |=> !O_SAMPLE)
      else $error("later bit sampled with sample-hold on");

   a_run_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      wr0 |=> (run_r == $past(I_WB_DAT[RUN_BIT])))
      else $error("run flag did not follow software write");

   a_pin_top: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (group_en && pin_sel == 3'h7) |=> (O_INPUT_SEL == 4'h8))
      else $error("top pin code did not pick the last input");

endmodule : adc_repeat_ctrl

// file: verilog/adc_sar_core.sv
// Successive-approximation register for 8- or 10-bit results
`timescale 1ns/1ps
module adc_sar_core (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_bit,
   input wire logic i_ten,
   input wire logic i_cmp,
   output logic [9:0] o_dac,
   output logic [9:0] o_result
);
   logic [9:0] mask_r;
   logic [9:0] first_mask;
   logic [9:0] keep;

   assign first_mask = i_ten ? 10'h200 : 10'h080;
   // Comparator high means the input is at or above the trial code
   assign keep = i_cmp ? o_dac : (o_dac & ~mask_r);
   assign o_result = o_dac;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_r <= 10'h000;
         o_dac <= 10'h000;
      end else if (i_start) begin
         mask_r <= first_mask;
         o_dac <= first_mask;
      end else if (i_bit && mask_r != 10'h000) begin
         mask_r <= mask_r >> 1;
         o_dac <= keep | (mask_r >> 1);
      end
   end

endmodule : adc_sar_core
